// >>> bench/doag_mem_model.sv
// far side: program and data memories watching both buses
module doag_mem_model (
    input wire logic clock,
    input wire logic sys_rst,
    input wire doag_pkg::doag_pbus_t pbus,
    input wire doag_pkg::doag_dbus_t dbus,
    output logic both_seen,
    output logic [doag_pkg::DATA_W-1:0] prog_word,
    output logic [doag_pkg::DATA_W-1:0] data_word
);
    timeunit 1ns;
    timeprecision 1ps;
    import doag_pkg::*;
    logic [DATA_W-1:0] prog_mem [0:255];
    logic [DATA_W-1:0] data_mem [0:255];
    // recognisable contents: top nibble names the space, low byte the address
    initial begin
        for (int i = 0; i < 256; i++) begin
            prog_mem[i] = 16'h5000 + 16'(i);
            data_mem[i] = 16'hA000 + 16'(i);
        end
    end
    // separate ports: fetch and data read may land together
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            both_seen <= 1'b0;
            prog_word <= 16'h0000;
            data_word <= 16'h0000;
        end else begin
            if (pbus.fetch_en) begin
                prog_word <= prog_mem[pbus.fetch_addr[7:0]];
            end
            if (dbus.rd_en) begin
                data_word <= data_mem[dbus.addr[7:0]];
            end
            both_seen <= pbus.fetch_en && dbus.rd_en;
        end
    end
endmodule

// >>> bench/doag_operand_addr_test.sv
module doag_operand_addr_test;
    timeunit 1ns;
    timeprecision 1ps;
    import doag_pkg::*;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic stall = 1'b0;
    doag_dec_t dec = '0;
    doag_pbus_t pbus;
    doag_dbus_t dbus;
    logic [PAGE_W-1:0] page_pointer;
    logic [SEL_W-1:0] pointer_select;
    logic both_seen;
    logic [DATA_W-1:0] prog_word;
    logic [DATA_W-1:0] data_word;
    int err_total = 0;
    int comparisons = 0;
    doag_dec_t d;
    always #2 clock = ~clock;
    doag_operand_addr dut (.clock(clock), .sys_rst(sys_rst), .dec(dec), .stall(stall),
        .pbus(pbus), .dbus(dbus), .page_pointer(page_pointer), .pointer_select(pointer_select));
    doag_mem_model mem (.clock(clock), .sys_rst(sys_rst), .pbus(pbus), .dbus(dbus),
        .both_seen(both_seen), .prog_word(prog_word), .data_word(data_word));
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // one valid instruction, taken unless stall is high; results are settled at the following falling edge;
    // dec keeps the word, so back-to-back calls never assign it twice in one step
    task automatic issue(doag_dec_t x);
        x.valid = 1'b1;
        dec = x;
        @(negedge clock);
    endtask
    // one cycle with nothing offered
    task automatic idle();
        dec = '0;
        @(negedge clock);
    endtask
    function automatic doag_dec_t mk(doag_mode_t m, logic [15:0] w);
        mk = '0;
        mk.mode = m;
        mk.word = w;
    endfunction
    task automatic t_direct();
        d = mk(DOAG_DIRECT, 16'h0000);
        d.load_page_instr = 1'b1;
        d.load_value = 16'h01A5;
        issue(d);
        chk("page", 16'h01A5, 16'(page_pointer));
        issue(mk(DOAG_DIRECT, 16'hFFC3));
        chk("rd_en", 16'h0001, 16'(dbus.rd_en));
        chk("addr", 16'hD2C3, dbus.addr);
        chk("fetch", 16'h0001, 16'(pbus.fetch_en));
        idle();
        chk("both", 16'h0001, 16'(both_seen));
        chk("data_word", 16'hA0C3, data_word);
    endtask
    task automatic t_sel(logic [2:0] s);
        d = mk(DOAG_IMMEDIATE, 16'h0000);
        d.load_status_instr = 1'b1;
        d.load_value = {s, 13'h00C3};
        issue(d);
        chk("st_page", 16'h00C3, 16'(page_pointer));
        chk("sel", 16'(s), 16'(pointer_select));
    endtask
    task automatic t_indirect();
        for (int i = 0; i < 8; i++) begin
            d = mk(DOAG_IMMEDIATE, 16'h0000);
            d.ptr_write = 1'b1;
            d.ptr_write_idx = 3'(i);
            d.ptr_write_val = 16'h0800 + 16'(i);
            issue(d);
        end
        for (int i = 7; i >= 0; i--) begin
            t_sel(3'(i));
            issue(mk(DOAG_INDIRECT, 16'h0000));
            chk("ind_addr", 16'h0800 + 16'(i), dbus.addr);
        end
    endtask
    task automatic t_upd();
        logic [15:0] pc_seen;
        t_sel(3'h5);
        d = mk(DOAG_INDIRECT, 16'h0000);
        d.upd = DOAG_UPD_INC;
        d.new_sel_en = 1'b1;
        d.new_sel = 3'h6;
        issue(d);
        chk("inc_addr", 16'h0805, dbus.addr);
        chk("new_sel", 16'h0006, 16'(pointer_select));
        pc_seen = pbus.fetch_addr;
        d = mk(DOAG_INDIRECT, 16'h0000);
        d.upd = DOAG_UPD_DEC;
        issue(d);
        chk("dec_addr", 16'h0806, dbus.addr);
        chk("pc_next", pc_seen + 16'h0001, pbus.fetch_addr);
        d.upd = DOAG_UPD_SUB_STEP;
        issue(d);
        chk("sub_addr", 16'h0805, dbus.addr);
        t_sel(3'h5);
        issue(mk(DOAG_INDIRECT, 16'h0000));
        chk("inc_done", 16'h0806, dbus.addr);
        t_sel(3'h6);
        issue(mk(DOAG_INDIRECT, 16'h0000));
        chk("sub_done", 16'h0005, dbus.addr);
    endtask
    task automatic t_step();
        t_sel(3'h3);
        d = mk(DOAG_INDIRECT, 16'h0000);
        d.upd = DOAG_UPD_ADD_STEP;
        issue(d);
        chk("pre_upd", 16'h0803, dbus.addr);
        chk("cmp_ne", 16'h0000, 16'(dbus.cmp_eq));
        issue(mk(DOAG_INDIRECT, 16'h0000));
        chk("stepped", 16'h1003, dbus.addr);
        t_sel(3'h0);
        issue(mk(DOAG_INDIRECT, 16'h0000));
        chk("cmp_eq", 16'h0001, 16'(dbus.cmp_eq));
    endtask
    task automatic t_imm_reg();
        issue(mk(DOAG_IMMEDIATE, 16'hBEEF));
        chk("imm", 16'hBEEF, dbus.imm_valid ? dbus.imm : 16'h0000);
        chk("imm_rd", 16'h0000, 16'(dbus.rd_en));
        issue(mk(DOAG_REGISTER, 16'h0006));
        chk("reg", 16'h0006, dbus.reg_valid ? 16'(dbus.reg_idx) : 16'h0000);
    endtask
    task automatic t_prog_stall();
        d = mk(DOAG_DIRECT, 16'h0000);
        d.prog_read = 1'b1;
        d.prog_read_addr = 16'h4321;
        issue(d);
        chk("prog_addr", 16'h4321, pbus.fetch_addr);
        chk("prog_rd", 16'h0000, 16'(dbus.rd_en));
        stall = 1'b1;
        issue(mk(DOAG_IMMEDIATE, 16'h1234));
        chk("stall_imm", 16'h0000, 16'(dbus.imm_valid));
        chk("stall_fetch", 16'h0000, 16'(pbus.fetch_en));
        chk("prog_word", 16'h5021, prog_word);
        stall = 1'b0;
    endtask
    // reset in mid-run: state cleared, first instruction right after release
    task automatic t_reset();
        sys_rst = 1'b1;
        dec = '0;
        repeat (2) @(negedge clock);
        chk("rst_page2", 16'h0000, 16'(page_pointer));
        chk("rst_sel", 16'h0000, 16'(pointer_select));
        chk("rst_fetch", 16'h0000, 16'(pbus.fetch_en));
        sys_rst = 1'b0;
        issue(mk(DOAG_INDIRECT, 16'h0000));
        chk("rst_rd", 16'h0001, 16'(dbus.rd_en));
        chk("rst_ptr", 16'h0000, dbus.addr);
        chk("rst_pc", 16'h0000, pbus.fetch_addr);
    endtask
    // watchdog against a hung run
    initial begin
        #100000;
        err_total++;
        summarize();
    end
    initial begin
        repeat (12) @(negedge clock);
        chk("rst_page", 16'h0000, 16'(page_pointer));
        sys_rst = 1'b0;
        t_direct();
        t_indirect();
        t_upd();
        t_step();
        t_imm_reg();
        t_prog_stall();
        t_reset();
        summarize();
    end
endmodule

// >>> hdl/doag_operand_addr.sv
// Overview of operation
// - four modes: direct, indirect, immediate, register
// - direct address is page pointer plus seven bits
// - indirect address is whole selected pointer
// - eight pointers, selector 0-7 picks one
// - separate program and data buses, concurrent
// - program memory readable as data source
// - four-deep pipeline, one instruction per cycle
// - next instruction prefetched during execution
// - page pointer loaded by page or status load
// - pointer zero is step and compare value
module doag_operand_addr (
    input wire logic clock,
    input wire logic sys_rst,
    input wire doag_pkg::doag_dec_t dec,
    input wire logic stall,
    output doag_pkg::doag_pbus_t pbus,
    output doag_pkg::doag_dbus_t dbus,
    output logic [doag_pkg::PAGE_W-1:0] page_pointer,
    output logic [doag_pkg::SEL_W-1:0] pointer_select
);
    import doag_pkg::*;

    typedef struct packed {
        logic [PAGE_W-1:0] page_r;
        logic [SEL_W-1:0] sel_r;
        logic [PTR_CNT-1:0][ADDR_W-1:0] ptr_r;
        logic [ADDR_W-1:0] pc_r;
        logic [PIPE_DEPTH-1:0] stage_r;
        doag_pbus_t pbus_r;
        doag_dbus_t dbus_r;
    } doag_state_t;

    doag_state_t st_r;
    doag_state_t st_nxt;

    // concatenation of page and offset, no adder in the path
    function automatic logic [ADDR_W-1:0] direct_addr(input logic [PAGE_W-1:0] pg,
                                                      input logic [DATA_W-1:0] w);
        return {pg, w[OFFS_W-1:0]};
    endfunction

    // pointer arithmetic unit, unsigned wrap-around
    function automatic logic [ADDR_W-1:0] ptr_update(input logic [ADDR_W-1:0] p,
                                                     input doag_upd_t u,
                                                     input logic [ADDR_W-1:0] step);
        unique case (u)
            DOAG_UPD_NONE: return p;
            DOAG_UPD_INC: return p + 16'h0001;
            DOAG_UPD_DEC: return p - 16'h0001;
            DOAG_UPD_ADD_STEP: return p + step;
            DOAG_UPD_SUB_STEP: return p - step;
            default: return p;
        endcase
    endfunction

    logic [ADDR_W-1:0] cur_ptr;
    logic [ADDR_W-1:0] op_addr;
    logic take;
    // selected pointer read port and intake strobe
    assign cur_ptr = st_r.ptr_r[st_r.sel_r];
    assign take = dec.valid && !stall;

    // operand address mux, same cycle as decode
    always_comb begin
        unique case (dec.mode)
            DOAG_DIRECT: op_addr = direct_addr(st_r.page_r, dec.word);
            DOAG_INDIRECT: op_addr = cur_ptr;
            DOAG_IMMEDIATE, DOAG_REGISTER: op_addr = {ADDR_W{1'b0}};
        endcase
    end

    // next-state logic
    always_comb begin
        st_nxt = st_r;
        st_nxt.pbus_r.fetch_en = !stall;
        st_nxt.pbus_r.fetch_addr = st_r.pc_r;
        if (!stall) begin
            st_nxt.pc_r = st_r.pc_r + 16'h0001;
        end
        // fetch, decode, operand, execute occupancy
        st_nxt.stage_r = {st_r.stage_r[PIPE_DEPTH-2:0], !stall};
        st_nxt.dbus_r = '0;
        if (take) begin
            unique case (dec.mode)
                DOAG_DIRECT, DOAG_INDIRECT: begin
                    st_nxt.dbus_r.rd_en = 1'b1;
                    st_nxt.dbus_r.addr = op_addr;
                end
                DOAG_IMMEDIATE: begin
                    st_nxt.dbus_r.imm_valid = 1'b1;
                    st_nxt.dbus_r.imm = dec.word;
                end
                DOAG_REGISTER: begin
                    st_nxt.dbus_r.reg_valid = 1'b1;
                    st_nxt.dbus_r.reg_idx = dec.word[SEL_W-1:0];
                end
            endcase
            if (dec.prog_read) begin
                // coefficient read from program space takes the fetch slot; the data read is dropped and the pc holds
                st_nxt.dbus_r.rd_en = 1'b0;
                st_nxt.pbus_r.fetch_en = 1'b1;
                st_nxt.pbus_r.fetch_addr = dec.prog_read_addr;
                st_nxt.pc_r = st_r.pc_r;
            end
            st_nxt.dbus_r.cmp_eq = (cur_ptr == st_r.ptr_r[0]);
            if (dec.mode == DOAG_INDIRECT) begin
                st_nxt.ptr_r[st_r.sel_r] =
                    ptr_update(cur_ptr, dec.upd, st_r.ptr_r[0]);
                if (dec.new_sel_en) begin
                    st_nxt.sel_r = dec.new_sel;
                end
            end
            if (dec.ptr_write) begin
                st_nxt.ptr_r[dec.ptr_write_idx] = dec.ptr_write_val;
            end
            if (dec.load_page_instr) begin
                st_nxt.page_r = dec.load_value[PAGE_W-1:0];
            end else if (dec.load_status_instr) begin
                st_nxt.page_r = dec.load_value[ST_PAGE_LSB +: PAGE_W];
                st_nxt.sel_r = dec.load_value[ST_SEL_LSB +: SEL_W];
            end
        end
        if (sys_rst) begin
            st_nxt.page_r = PAGE_RST;
            st_nxt.sel_r = SEL_RST;
            st_nxt.ptr_r = {PTR_CNT{PTR_RST}};
            st_nxt.pc_r = PC_RST;
            st_nxt.stage_r = '0;
            st_nxt.pbus_r = '0;
            st_nxt.dbus_r = '0;
        end
    end

    // single state register; the synchronous reset is folded into st_nxt
    always_ff @(posedge clock) begin
        st_r <= st_nxt;
    end

    // outputs straight from the state register, no logic after the flops
    assign pbus = st_r.pbus_r;
    assign dbus = st_r.dbus_r;
    assign page_pointer = st_r.page_r;
    assign pointer_select = st_r.sel_r;

    // operand address checks, one cycle after the taking edge
    a_direct_addr_form: assert property (@(posedge clock) disable iff (sys_rst)
        take && dec.mode == DOAG_DIRECT && !dec.prog_read
        |=> dbus.rd_en && dbus.addr == {$past(page_pointer), $past(dec.word[OFFS_W-1:0])})
        else $error("direct address wrong");
    // expectation indexes the pointer file directly, not through cur_ptr
    a_indirect_addr: assert property (@(posedge clock) disable iff (sys_rst)
        take && dec.mode == DOAG_INDIRECT && !dec.prog_read
        |=> dbus.rd_en && dbus.addr == $past(st_r.ptr_r[pointer_select]))
        else $error("indirect address wrong");
    a_imm_mode: assert property (@(posedge clock) disable iff (sys_rst)
        take && dec.mode == DOAG_IMMEDIATE && !dec.prog_read
        |=> dbus.imm_valid && !dbus.rd_en && dbus.imm == $past(dec.word))
        else $error("immediate mode wrong");
    a_reg_mode: assert property (@(posedge clock) disable iff (sys_rst)
        take && dec.mode == DOAG_REGISTER
        |=> dbus.reg_valid && !dbus.rd_en && dbus.reg_idx == $past(dec.word[SEL_W-1:0]))
        else $error("register mode wrong");

    // page pointer and selector loads; page holds otherwise, selector also moves on an indirect new_sel
    a_page_load: assert property (@(posedge clock) disable iff (sys_rst)
        take && dec.load_page_instr |=> page_pointer == $past(dec.load_value[PAGE_W-1:0]))
        else $error("page load lost");
    a_status_load: assert property (@(posedge clock) disable iff (sys_rst)
        take && dec.load_status_instr && !dec.load_page_instr
        |=> page_pointer == $past(dec.load_value[ST_PAGE_LSB +: PAGE_W])
        && pointer_select == $past(dec.load_value[ST_SEL_LSB +: SEL_W]))
        else $error("status load lost");
    a_page_hold: assert property (@(posedge clock) disable iff (sys_rst)
        !(take && (dec.load_page_instr || dec.load_status_instr)) |=> $stable(page_pointer))
        else $error("page changed unexpectedly");
    a_sel_hold: assert property (@(posedge clock) disable iff (sys_rst)
        !(take && (dec.load_status_instr || (dec.mode == DOAG_INDIRECT && dec.new_sel_en)))
        |=> $stable(pointer_select))
        else $error("selector changed unexpectedly");

    // prefetch: runs every free cycle, sequential, silent under stall
    a_prefetch_run: assert property (@(posedge clock) disable iff (sys_rst)
        !stall && !(take && dec.prog_read) |=> pbus.fetch_en)
        else $error("no prefetch");
    a_fetch_step: assert property (@(posedge clock) disable iff (sys_rst)
        !stall && !(take && dec.prog_read) ##1 !stall && !(take && dec.prog_read)
        |=> pbus.fetch_addr == $past(pbus.fetch_addr) + 16'h0001)
        else $error("fetch address not sequential");
    a_stall_quiet: assert property (@(posedge clock) disable iff (sys_rst)
        stall |=> !pbus.fetch_en && !dbus.rd_en && !dbus.imm_valid && !dbus.reg_valid)
        else $error("activity during stall");
    a_pipe_fill: assert property (@(posedge clock) disable iff (sys_rst)
        !stall [*4] |=> st_r.stage_r == {PIPE_DEPTH{1'b1}})
        else $error("pipeline not full");

    // bus separation and program-space reads
    a_concurrent_bus: assert property (@(posedge clock) disable iff (sys_rst)
        take && !stall && dec.mode == DOAG_DIRECT && !dec.prog_read
        |=> pbus.fetch_en && dbus.rd_en)
        else $error("buses not concurrent");
    a_prog_read: assert property (@(posedge clock) disable iff (sys_rst)
        take && dec.prog_read |=> pbus.fetch_en && pbus.fetch_addr == $past(dec.prog_read_addr))
        else $error("program read missed");

    // pointer file updates and the pointer zero compare
    a_step_add: assert property (@(posedge clock) disable iff (sys_rst)
        take && dec.mode == DOAG_INDIRECT && dec.upd == DOAG_UPD_ADD_STEP
        && !dec.ptr_write && pointer_select != '0
        |=> st_r.ptr_r[$past(pointer_select)] == $past(cur_ptr) + $past(st_r.ptr_r[0]))
        else $error("step update wrong");
    a_cmp_zero: assert property (@(posedge clock) disable iff (sys_rst)
        take |=> dbus.cmp_eq == ($past(st_r.ptr_r[pointer_select]) == $past(st_r.ptr_r[0])))
        else $error("pointer compare wrong");
    a_ptr_write: assert property (@(posedge clock) disable iff (sys_rst)
        take && dec.ptr_write
        |=> st_r.ptr_r[$past(dec.ptr_write_idx)] == $past(dec.ptr_write_val))
        else $error("pointer write lost");
endmodule

// >>> pkg/doag_pkg.sv
package doag_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int PAGE_W = 9;
    localparam int OFFS_W = 7;
    localparam int PTR_CNT = 8;
    localparam int SEL_W = 3;
    localparam int PIPE_DEPTH = 4;
    localparam logic [PAGE_W-1:0] PAGE_RST = 9'h000;
    localparam logic [ADDR_W-1:0] PTR_RST = 16'h0000;
    localparam logic [ADDR_W-1:0] PC_RST = 16'h0000;
    localparam logic [SEL_W-1:0] SEL_RST = 3'h0;
    // field positions inside a status word loaded by the status load
    localparam int ST_PAGE_LSB = 0;
    localparam int ST_SEL_LSB = 13;

    typedef enum logic [1:0] {
        DOAG_DIRECT,
        DOAG_INDIRECT,
        DOAG_IMMEDIATE,
        DOAG_REGISTER
    } doag_mode_t;

    // pointer update operation in indirect mode
    typedef enum logic [2:0] {
        DOAG_UPD_NONE,
        DOAG_UPD_INC,
        DOAG_UPD_DEC,
        DOAG_UPD_ADD_STEP,
        DOAG_UPD_SUB_STEP
    } doag_upd_t;

    // decoded instruction as handed over by the decoder
    typedef struct packed {
        logic valid;
        doag_mode_t mode;
        logic [DATA_W-1:0] word;
        doag_upd_t upd;
        logic new_sel_en;
        logic [SEL_W-1:0] new_sel;
        logic load_page_instr;
        logic load_status_instr;
        logic [DATA_W-1:0] load_value;
        logic ptr_write;
        logic [SEL_W-1:0] ptr_write_idx;
        logic [DATA_W-1:0] ptr_write_val;
        logic prog_read;
        logic [ADDR_W-1:0] prog_read_addr;
    } doag_dec_t;

    typedef struct packed {
        logic fetch_en;
        logic [ADDR_W-1:0] fetch_addr;
    } doag_pbus_t;

    typedef struct packed {
        logic rd_en;
        logic [ADDR_W-1:0] addr;
        logic imm_valid;
        logic [DATA_W-1:0] imm;
        logic reg_valid;
        logic [SEL_W-1:0] reg_idx;
        logic cmp_eq;
    } doag_dbus_t;
endpackage
